/* File: pkg/uep_defines.svh */
// timing constants for the eprom programming controller
`ifndef UEP_DEFINES_SVH
`define UEP_DEFINES_SVH

`define UEP_CLK_NS      40      // mclk period in ns
`define UEP_T_SETUP_NS  1000    // address, data, gate, supply setup
`define UEP_T_DH_NS     1000    // data hold after the pulse
`define UEP_T_PW_NS     100000  // program pulse width
`define UEP_T_DF_NS     60      // output float delay, longest
`define UEP_T_OE_NS     100     // data valid from gate, longest
`define UEP_MAX_PULSES  25      // pulse ceiling per address
`define UEP_ADDR_W      19      // address pins
`define UEP_DATA_W      8       // data pins
`define UEP_TMR_W       12      // timer width
`define UEP_CNT_W       5       // pulse counter width

// cycle counts, rounded up: all are least waits from the controller's view
`define UEP_CYC(ns) (((ns) + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_SETUP_CYC `UEP_CYC(`UEP_T_SETUP_NS)
`define UEP_DH_CYC    `UEP_CYC(`UEP_T_DH_NS)
`define UEP_PW_CYC    `UEP_CYC(`UEP_T_PW_NS)
`define UEP_DF_CYC    `UEP_CYC(`UEP_T_DF_NS)
`define UEP_OE_CYC    `UEP_CYC(`UEP_T_OE_NS)

`endif

/* File: pkg/uep_pkg.sv */
// types of the eprom programming controller
`include "uep_defines.svh"
`default_nettype none
package uep_pkg;
	// command kinds
	typedef enum logic [1:0] {
		UEP_CMD_READ = 2'b00,  // plain read of one byte
		UEP_CMD_PROG = 2'b01,  // pulse and verify one byte
		UEP_CMD_ID   = 2'b10   // identification byte, addr[0] selects
	} uep_cmd_type;

	// request from the user side
	typedef struct packed {
		uep_cmd_type                kind;  // what to do
		logic [`UEP_ADDR_W-1:0]     addr;  // target address
		logic [`UEP_DATA_W-1:0]     data;  // byte to program
	} uep_req_type;

	// answer to the user side
	typedef struct packed {
		logic [`UEP_DATA_W-1:0]     data;    // byte read back
		logic                       fail;    // program did not verify
		logic [`UEP_CNT_W-1:0]      pulses;  // pulses used
	} uep_rsp_type;
endpackage
`default_nettype wire

/* File: rtl/uep_programmer.sv */
// eprom programmer: drives program, verify, read and id pins of the part
// Function
// - raise supply and hold gate high first
// - drive all eight data bits while programming
// - pulse strobe low only after stable address, data
// - 100 us pulses, verify each, at most 25
// - never program with strobe held low
// - shared strobe programs all paralleled parts
// - verify with gate low, supply still raised
// - supply at normal level outside program, verify
// - id: raise address line, select maker or type
// - read data only with strobe and gate low
// - strobe high no later than supply raised
`include "uep_defines.svh"
`default_nettype none
module uep_programmer
	import uep_pkg::*;
(
	input  wire logic                   mclk_i,        // 25 mhz clock
	input  wire logic                   reset_n_i,     // async reset, low
	input  wire logic                   req_valid_i,   // command offered
	input  wire uep_req_type            req_i,         // command
	output logic                        req_ready_o,   // idle, takes command
	output logic                        done_o,        // one-cycle answer
	output uep_rsp_type                 rsp_o,         // answer contents
	output logic [`UEP_ADDR_W-1:0]      addr_o,        // address pins
	output logic [`UEP_DATA_W-1:0]      data_pins_o,   // data toward part
	output logic                        data_pins_oe_o, // drive data pins
	input  wire logic [`UEP_DATA_W-1:0] data_pins_i,   // data from part
	output logic                        select_and_program_strobe_n_o, // low
	output logic                        output_gate_n_o, // gate, low active
	output logic                        vpp_high_o,    // raised supply on
	output logic                        id_hv_o        // id address line hv
);
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,  // waiting for a command
		ST_PWR_UP = 4'h1,  // supply rising, strobe high
		ST_SETUP  = 4'h2,  // address and data settle
		ST_PULSE  = 4'h3,  // strobe low for one pulse
		ST_HOLD   = 4'h4,  // strobe high, data held
		ST_FLOAT  = 4'h5,  // release data pins
		ST_VREAD  = 4'h6,  // gate low, wait for data
		ST_VRET   = 4'h7,  // gate high, part floats
		ST_PWR_DN = 4'h8,  // supply back to normal
		ST_RD     = 4'h9,  // read or id access
		ST_RD_END = 4'ha   // controls released, part floats
	} uep_state_type;

	uep_state_type           state_q, state_d;   // sequencer state
	logic [`UEP_TMR_W-1:0]   tmr_q, tmr_d;       // wait timer
	uep_req_type             req_q, req_d;       // latched command
	uep_rsp_type             rsp_q, rsp_d;       // answer register
	logic                    done_q, done_d;     // answer pulse
	logic [`UEP_ADDR_W-1:0]  addr_q, addr_d;     // address pins
	logic [`UEP_DATA_W-1:0]  dout_q, dout_d;     // data pins out
	logic                    doe_q, doe_d;       // data pins enable
	logic                    strb_n_q, strb_n_d; // strobe level
	logic                    gate_n_q, gate_n_d; // gate level
	logic                    vpp_q, vpp_d;       // raised supply request
	logic                    idhv_q, idhv_d;     // id high voltage
	logic                    tmr_done;           // timer expired

	assign tmr_done = (tmr_q == '0);

	// next-state and pin sequencing
	always_comb begin
		state_d  = state_q;
		tmr_d    = tmr_done ? tmr_q : tmr_q - 1'b1;
		req_d    = req_q;
		rsp_d    = rsp_q;
		done_d   = 1'b0;
		addr_d   = addr_q;
		dout_d   = dout_q;
		doe_d    = doe_q;
		strb_n_d = strb_n_q;
		gate_n_d = gate_n_q;
		vpp_d    = vpp_q;
		idhv_d   = idhv_q;
		case (state_q)
			ST_IDLE: begin
				if (req_valid_i) begin
					req_d        = req_i;
					rsp_d        = '0;
					addr_d       = req_i.addr;
					strb_n_d     = 1'b1;
					gate_n_d     = 1'b1;
					case (req_i.kind)
						UEP_CMD_PROG: begin
							vpp_d   = 1'b1;
							tmr_d   = `UEP_TMR_W'(`UEP_SETUP_CYC - 1);
							state_d = ST_PWR_UP;
						end
						UEP_CMD_ID: begin
							// other address lines and controls low
							addr_d   = {{(`UEP_ADDR_W-1){1'b0}},
								req_i.addr[0]};
							idhv_d   = 1'b1;
							strb_n_d = 1'b0;
							gate_n_d = 1'b0;
							tmr_d    = `UEP_TMR_W'(`UEP_SETUP_CYC - 1);
							state_d  = ST_RD;
						end
						default: begin
							strb_n_d = 1'b0;
							gate_n_d = 1'b0;
							tmr_d    = `UEP_TMR_W'(`UEP_SETUP_CYC - 1);
							state_d  = ST_RD;
						end
					endcase
				end
			end
			ST_PWR_UP: begin
				// supply and gate settle before data goes out
				if (tmr_done) begin
					dout_d  = req_q.data;
					doe_d   = 1'b1;
					tmr_d   = `UEP_TMR_W'(`UEP_SETUP_CYC - 1);
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// address and data stable before the strobe falls
				if (tmr_done) begin
					strb_n_d   = 1'b0;
					rsp_d.pulses = rsp_q.pulses + 1'b1;
					tmr_d      = `UEP_TMR_W'(`UEP_PW_CYC - 1);
					state_d    = ST_PULSE;
				end
			end
			ST_PULSE: begin
				// timed pulse, never a steady low
				if (tmr_done) begin
					strb_n_d = 1'b1;
					tmr_d    = `UEP_TMR_W'(`UEP_DH_CYC - 1);
					state_d  = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// data hold, then free the pins for verify
				if (tmr_done) begin
					doe_d   = 1'b0;
					tmr_d   = `UEP_TMR_W'(`UEP_DF_CYC - 1);
					state_d = ST_FLOAT;
				end
			end
			ST_FLOAT: begin
				if (tmr_done) begin
					gate_n_d = 1'b0;
					tmr_d    = `UEP_TMR_W'(`UEP_OE_CYC - 1);
					state_d  = ST_VREAD;
				end
			end
			ST_VREAD: begin
				// compare verify data with the wanted byte
				if (tmr_done) begin
					rsp_d.data = data_pins_i;
					gate_n_d   = 1'b1;
					tmr_d      = `UEP_TMR_W'(`UEP_DF_CYC - 1);
					if (data_pins_i == req_q.data) begin
						state_d = ST_PWR_DN;
					end else if (rsp_q.pulses ==
						`UEP_CNT_W'(`UEP_MAX_PULSES)) begin
						rsp_d.fail = 1'b1;
						state_d    = ST_PWR_DN;
					end else begin
						state_d = ST_VRET;
					end
				end
			end
			ST_VRET: begin
				// part floats before the controller drives again
				if (tmr_done) begin
					dout_d  = req_q.data;
					doe_d   = 1'b1;
					tmr_d   = `UEP_TMR_W'(`UEP_SETUP_CYC - 1);
					state_d = ST_SETUP;
				end
			end
			ST_PWR_DN: begin
				// drop supply, answer once it has settled
				vpp_d = 1'b0;
				if (tmr_done && !vpp_q) begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end else if (tmr_done) begin
					tmr_d = `UEP_TMR_W'(`UEP_SETUP_CYC - 1);
				end
			end
			ST_RD: begin
				// sample read or id byte
				if (tmr_done) begin
					rsp_d.data = data_pins_i;
					strb_n_d   = 1'b1;
					gate_n_d   = 1'b1;
					idhv_d     = 1'b0;
					tmr_d      = `UEP_TMR_W'(`UEP_DF_CYC - 1);
					state_d    = ST_RD_END;
				end
			end
			ST_RD_END: begin
				if (tmr_done) begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q  <= ST_IDLE;
			tmr_q    <= '0;
			req_q    <= '0;
			rsp_q    <= '0;
			done_q   <= 1'b0;
			addr_q   <= '0;
			dout_q   <= '0;
			doe_q    <= 1'b0;
			strb_n_q <= 1'b1;
			gate_n_q <= 1'b1;
			vpp_q    <= 1'b0;
			idhv_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			tmr_q    <= tmr_d;
			req_q    <= req_d;
			rsp_q    <= rsp_d;
			done_q   <= done_d;
			addr_q   <= addr_d;
			dout_q   <= dout_d;
			doe_q    <= doe_d;
			strb_n_q <= strb_n_d;
			gate_n_q <= gate_n_d;
			vpp_q    <= vpp_d;
			idhv_q   <= idhv_d;
		end
	end

	// outputs
	assign req_ready_o                   = (state_q == ST_IDLE);
	assign done_o                        = done_q;
	assign rsp_o                         = rsp_q;
	assign addr_o                        = addr_q;
	assign data_pins_o                   = dout_q;
	assign data_pins_oe_o                = doe_q;
	assign select_and_program_strobe_n_o = strb_n_q;
	assign output_gate_n_o               = gate_n_q;
	assign vpp_high_o                    = vpp_q;
	assign id_hv_o                       = idhv_q;
endmodule // uep_programmer
`default_nettype wire

/* File: verification/uep_eprom_model.sv */
// behavioural eprom part on the far side of the programmer
`default_nettype none
module uep_eprom_model
	import uep_pkg::*;
#(
	parameter logic [7:0] MAKER  = 8'h3c, // arbitrary maker byte
	parameter logic [7:0] DEVICE = 8'h5c  // arbitrary device byte
)(
	input  wire logic [18:0] addr_i, // address pins
	input  wire logic [7:0]  data_i, // data from programmer
	input  wire logic        oe_i,   // programmer drives data
	input  wire logic        st_n_i, // select and strobe
	input  wire logic        gt_n_i, // output gate
	input  wire logic        vpp_i,  // supply raised
	input  wire logic        id_i,   // id line raised
	input  wire logic [4:0]  need_i, // pulses a byte needs
	output logic [7:0]       data_o  // data toward programmer
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];    // low address bits only
	logic [7:0] last = 8'h00; // last byte driven
	logic [4:0] cnt = 5'h00;  // pulses since supply rose
	logic       drv;          // part drives its pins
	logic [7:0] val;          // byte it would drive
	initial foreach (mem[i]) mem[i] = 8'hff;
	always @(posedge vpp_i) cnt = 5'h00;
	// end of a strobe pulse: clear only the zero bits
	always @(posedge st_n_i) begin
		if (vpp_i && gt_n_i && oe_i) begin
			cnt = cnt + 5'h01;
			if (cnt >= need_i)
				mem[addr_i[7:0]] &= data_i;
		end
	end
	assign drv = !gt_n_i && (!st_n_i || vpp_i);
	assign val = id_i ? (addr_i[0] ? DEVICE : MAKER)
		: mem[addr_i[7:0]];
	// released pins show the inverse of the last byte
	always @(val or drv)
		if (drv)
			last = val;
	assign data_o = drv ? val : ~last;
endmodule // uep_eprom_model
`default_nettype wire

/* File: verification/uep_programmer_asserts.sv */
// port assertions for the eprom programming controller
`default_nettype none
module uep_programmer_asserts
	import uep_pkg::*;
(
	input wire logic        mclk_i,         // clock
	input wire logic        reset_n_i,      // reset
	input wire logic        req_valid_i,    // offer
	input wire uep_req_type req_i,          // command
	input wire logic        req_ready_o,    // ready
	input wire logic        done_o,         // answer
	input wire uep_rsp_type rsp_o,          // result
	input wire logic [18:0] addr_o,         // address
	input wire logic [7:0]  data_pins_o,    // data out
	input wire logic        data_pins_oe_o, // drive
	input wire logic        select_and_program_strobe_n_o, // strobe
	input wire logic        output_gate_n_o, // gate
	input wire logic        vpp_high_o,     // supply up
	input wire logic        id_hv_o         // id line up
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        s;          // strobe alias
	logic [11:0] pw_q, pw_d; // strobe low run
	assign s = select_and_program_strobe_n_o;
	// run length of the strobe low level
	always_comb pw_d = s ? 12'h000 : pw_q + 12'h001;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pw_q <= 12'h000;
		else
			pw_q <= pw_d;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_rd; req_valid_i && req_ready_o &&
		req_i.kind != UEP_CMD_PROG; endsequence
	sequence s_go; $fell(s) && vpp_high_o; endsequence
	sequence s_end; $rose(s) && vpp_high_o; endsequence
	property p_rd; s_rd |-> ##28 done_o; endproperty
	a_rd: assert property (p_rd) else $error("read time");
	property p_pw; s_end |-> pw_q == 12'h9c4; endproperty
	a_pw: assert property (p_pw) else $error("pulse width");
	property p_set; s_go |-> $past(data_pins_oe_o, 25) &&
		$past(data_pins_o, 25) == data_pins_o; endproperty
	a_set: assert property (p_set) else $error("setup");
	property p_ctx; !s && vpp_high_o |-> output_gate_n_o &&
		data_pins_oe_o; endproperty
	a_ctx: assert property (p_ctx) else $error("pulse ctx");
	property p_rdv; !s && !output_gate_n_o |-> !vpp_high_o; endproperty
	a_rdv: assert property (p_rdv) else $error("read vpp");
	property p_ver; vpp_high_o && !output_gate_n_o |-> s &&
		!data_pins_oe_o; endproperty
	a_ver: assert property (p_ver) else $error("verify");
	property p_id; id_hv_o |-> addr_o[18:1] == 18'h0 && !s &&
		!output_gate_n_o && !vpp_high_o; endproperty
	a_id: assert property (p_id) else $error("id pins");
	property p_up; $rose(vpp_high_o) |-> s; endproperty
	a_up: assert property (p_up) else $error("supply up");
	property p_fl; done_o && rsp_o.fail |-> rsp_o.pulses == 5'h19;
	endproperty
	a_fl: assert property (p_fl) else $error("fail count");
endmodule // uep_programmer_asserts
bind uep_programmer uep_programmer_asserts u_chk (.mclk_i, .reset_n_i,
	.req_valid_i, .req_i, .req_ready_o, .done_o, .rsp_o, .addr_o,
	.data_pins_o, .data_pins_oe_o, .select_and_program_strobe_n_o,
	.output_gate_n_o, .vpp_high_o, .id_hv_o);
`default_nettype wire

/* File: verification/test_uep_programmer.sv */
// self-checking bench for the eprom programming controller
`default_nettype none
module test_uep_programmer
	import uep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MK = 8'h3c; // arbitrary maker byte
	localparam logic [7:0] DV = 8'h5c; // arbitrary device byte
	logic        mclk, reset_n, req_valid, ready, done; // control
	logic        oe, st_n, gt_n, vpp, id_hv; // part pins
	uep_req_type req;                  // command
	uep_rsp_type rsp;                  // answer
	logic [18:0] addr;                 // address pins
	logic [7:0]  dout, mdat, pins;     // data paths
	logic [4:0]  need = 5'h01;         // pulses per byte
	int          miscompares, checks_done; // tallies
	assign pins = oe ? dout : mdat;
	uep_programmer dut (.mclk_i(mclk), .reset_n_i(reset_n),
		.req_valid_i(req_valid), .req_i(req), .req_ready_o(ready),
		.done_o(done), .rsp_o(rsp), .addr_o(addr), .data_pins_o(dout),
		.data_pins_oe_o(oe), .data_pins_i(pins), .vpp_high_o(vpp),
		.select_and_program_strobe_n_o(st_n), .output_gate_n_o(gt_n),
		.id_hv_o(id_hv));
	// two parts share every pin; only the first answers
	uep_eprom_model #(.MAKER(MK), .DEVICE(DV)) m1 (.addr_i(addr),
		.data_i(dout), .oe_i(oe), .st_n_i(st_n), .gt_n_i(gt_n),
		.vpp_i(vpp), .id_i(id_hv), .need_i(need), .data_o(mdat));
	uep_eprom_model #(.MAKER(MK), .DEVICE(DV)) m2 (.addr_i(addr),
		.data_i(dout), .oe_i(oe), .st_n_i(st_n), .gt_n_i(gt_n),
		.vpp_i(vpp), .id_i(id_hv), .need_i(need), .data_o());
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// offer one command, wait for its answer pulse
	task automatic cmd(input uep_cmd_type k, input logic [18:0] a,
			input logic [7:0] d);
		int n;
		n = 0;
		req = '{kind: k, addr: a, data: d};
		req_valid = 1'b1;
		while (ready !== 1'b1 && n < 9) begin
			@(posedge mclk);
			#1 n++;
		end
		@(posedge mclk);
		#1 req_valid = 1'b0;
		while (done !== 1'b1 && n < 70000) begin
			@(posedge mclk);
			#1 n++;
		end
		if (done !== 1'b1) begin
			miscompares++;
			conclude;
		end
	endtask
	// blank byte, then both id bytes
	task automatic t_read;
		cmd(UEP_CMD_READ, 19'h00012, 8'h00);
		check(rsp.data, 8'hff);
		cmd(UEP_CMD_ID, 19'h7fffe, 8'h00);
		check(rsp.data, MK);
		cmd(UEP_CMD_ID, 19'h00001, 8'h00);
		check(rsp.data, DV);
	endtask
	// program, retry, then a one over a stored zero
	task automatic t_prog;
		cmd(UEP_CMD_PROG, 19'h00012, 8'h5a);
		check({rsp.fail, rsp.pulses}, 8'h01);
		cmd(UEP_CMD_READ, 19'h00012, 8'h00);
		check(rsp.data, 8'h5a);
		check(m2.mem[8'h12], 8'h5a);
		need = 5'h03;
		cmd(UEP_CMD_PROG, 19'h00034, 8'h0f);
		check({rsp.fail, rsp.pulses}, 8'h03);
		cmd(UEP_CMD_PROG, 19'h00012, 8'hf5);
		check({rsp.fail, rsp.pulses}, 8'h39);
		cmd(UEP_CMD_READ, 19'h00012, 8'h00);
		check(rsp.data, 8'h50);
	endtask
	initial begin
		miscompares = 0;
		checks_done = 0;
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (6) @(posedge mclk);
		#1 check({st_n, gt_n, vpp, oe, id_hv, ready, done}, 8'h62);
		reset_n = 1'b1;
		t_read;
		t_prog;
		conclude;
	end
endmodule // test_uep_programmer
`default_nettype wire
